// [rtl/mcs_top.sv]
// Clock-rate selector: control registers on AHB-Lite, halving stage and cycle dividers.
`timescale 1ns/10ps
`default_nettype none
`include "mcs_regs.svh"
module mcs_top
    import mcs_pkg::*;
(
    // Crystal clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    // Double-speed request from the security configuration byte
    input wire logic SEC_CFG_DBL_I,
    // AHB-Lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Clock outputs
    output logic HALF_CLK_O,
    output logic CORE_TICK_O,
    output logic MACHINE_CYCLE_O,
    output logic [5:0] PERIPH_CYCLE_O,
    output logic DOUBLE_SPEED_O
);

    // Bus address phase capture.

    logic addr_valid;
    logic [7:0] addr_idx;
    logic wr_pend_q;
    logic wr_pend_d;
    logic [7:0] wr_idx_q;
    logic [7:0] wr_idx_d;

    // Only bits 9..2 are decoded, so the map repeats every 1 KiB.
    assign addr_valid = HSEL_I && HREADY_I && HTRANS_I[1];
    assign addr_idx = HADDR_I[9:2];

    always_comb begin
        wr_pend_d = addr_valid && HWRITE_I;
        wr_idx_d = addr_valid ? addr_idx : wr_idx_q;
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_idx_q <= wr_idx_d;
        end
    end

    // Control registers.

    mcs_byte_t ctrl0_q;
    mcs_byte_t ctrl0_d;
    mcs_byte_t ctrl1_q;
    mcs_byte_t ctrl1_d;
    logic boot_q;
    logic boot_d;
    logic wr_ctrl0;
    logic wr_ctrl1;

    assign wr_ctrl0 = wr_pend_q && (wr_idx_q == `MCS_CTRL0_IDX);
    assign wr_ctrl1 = wr_pend_q && (wr_idx_q == `MCS_CTRL1_IDX);

    // The strap is taken on the first edge after reset release, never under reset itself.
    always_comb begin
        ctrl0_d = ctrl0_q;
        ctrl1_d = ctrl1_q;
        boot_d = 1'b0;
        if (boot_q) begin
            ctrl0_d[`MCS_CTRL0_DBL_BIT] = SEC_CFG_DBL_I;
        end else if (wr_ctrl0) begin
            ctrl0_d = HWDATA_I[7:0] & `MCS_CTRL0_MASK;
        end
        if (wr_ctrl1) begin
            ctrl1_d = HWDATA_I[7:0] & `MCS_CTRL1_MASK;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl0_q <= `MCS_CTRL0_RESET;
            ctrl1_q <= `MCS_CTRL1_RESET;
            boot_q <= 1'b1;
        end else begin
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
            boot_q <= boot_d;
        end
    end

    // Halving stage and glitch-free mode switch.

    logic half_q;
    logic half_d;
    logic dbl_eff_q;
    logic dbl_eff_d;
    logic core_tick_q;
    logic core_tick_d;
    logic half_rise;

    // The halved clock rises on the edge where half_q goes from 0 to 1.
    assign half_rise = !half_q;

    always_comb begin
        half_d = ~half_q;
        // A new setting is applied only where the halved clock rises, so a
        // core tick is never cut short in the middle of a halved period.
        if (half_rise) begin
            dbl_eff_d = ctrl0_q[`MCS_CTRL0_DBL_BIT];
        end else begin
            dbl_eff_d = dbl_eff_q;
        end
        // Standard mode ticks once per halved period; double speed bypasses it.
        core_tick_d = dbl_eff_d ? 1'b1 : half_rise;
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            half_q <= 1'b0;
            dbl_eff_q <= 1'b0;
            core_tick_q <= 1'b0;
        end else begin
            half_q <= half_d;
            dbl_eff_q <= dbl_eff_d;
            core_tick_q <= core_tick_d;
        end
    end

    // Cycle dividers for the core and each peripheral.

    logic [MCS_NUM_DIV-1:0] sel_bit;
    logic [MCS_NUM_DIV-1:0] div_tick;

    // A set select bit asks for 12 periods; the core has no select bit.
    always_comb begin
        sel_bit = '0;
        sel_bit[MCS_CNT_ARRAY] = ctrl0_q[`MCS_CTRL0_CNT_BIT];
        sel_bit[MCS_SERIAL] = ctrl0_q[`MCS_CTRL0_SER_BIT];
        sel_bit[MCS_TIMER2] = ctrl0_q[`MCS_CTRL0_T2_BIT];
        sel_bit[MCS_TIMER1] = ctrl0_q[`MCS_CTRL0_T1_BIT];
        sel_bit[MCS_TIMER0] = ctrl0_q[`MCS_CTRL0_T0_BIT];
        sel_bit[MCS_SPI] = ctrl1_q[`MCS_CTRL1_SPI_BIT];
    end

    mcs_div_if div_lnk [MCS_NUM_DIV] ();

    for (genvar g = 0; g < MCS_NUM_DIV; g++) begin : g_div
        // Standard mode forces the long count everywhere; the select bits
        // only count once double speed is in effect.
        assign div_lnk[g].sel_long = !dbl_eff_q || sel_bit[g];
        assign div_tick[g] = div_lnk[g].tick;

        mcs_div #(
            .SHORT_PERIODS(`MCS_DBL_PERIODS),
            .LONG_PERIODS(`MCS_STD_PERIODS),
            .CNT_W(4)
        ) u_div (
            .clk_i(SYS_CLK_I),
            .rst_n_i(RST_N_I),
            .lnk(div_lnk[g])
        );
    end

    // Read data.

    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    mcs_byte_t ctrl0_view;
    mcs_byte_t ctrl1_view;
    mcs_byte_t status_view;

    // A read right behind a write sees the value being written, not the old one.
    always_comb begin
        ctrl0_view = wr_ctrl0 ? (HWDATA_I[7:0] & `MCS_CTRL0_MASK) : ctrl0_q;
        ctrl1_view = wr_ctrl1 ? (HWDATA_I[7:0] & `MCS_CTRL1_MASK) : ctrl1_q;
        status_view = 8'h00;
        status_view[`MCS_STAT_DBL_EFF_BIT] = dbl_eff_q;
        status_view[`MCS_STAT_DBL_PEND_BIT] = ctrl0_view[`MCS_CTRL0_DBL_BIT] ^ dbl_eff_q;
        status_view[`MCS_STAT_HALF_BIT] = half_q;
        rdata_d = 32'h0000_0000;
        if (addr_valid && !HWRITE_I) begin
            case (addr_idx)
                `MCS_CTRL0_IDX: rdata_d = {24'h00_0000, ctrl0_view};
                `MCS_CTRL1_IDX: rdata_d = {24'h00_0000, ctrl1_view};
                `MCS_STATUS_IDX: rdata_d = {24'h00_0000, status_view};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Outputs.

    assign HRDATA_O = rdata_q;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    assign HALF_CLK_O = half_q;
    assign CORE_TICK_O = core_tick_q;
    assign MACHINE_CYCLE_O = div_tick[MCS_CORE];
    assign PERIPH_CYCLE_O = div_tick[MCS_NUM_DIV-1:1];
    assign DOUBLE_SPEED_O = dbl_eff_q;

endmodule : mcs_top
`default_nettype wire

// [rtl/mcs_regs.svh]
// Register map, field positions, reset values and cycle counts of the clock-rate selector.
// Notes on behaviour
// - With double speed on, the core finishes a machine cycle in 6 input periods.
// - A halving stage sits before the core phase logic; software can bypass it.
// - In standard mode the halved clock times the core and all peripherals; here only CORE_TICK_O follows it, the dividers count SYS_CLK_I periods.
// - A new double-speed setting takes effect only on a rising edge of the halved clock.
// - Bit 5 picks 6 or 12 periods for the counter array, only with double speed.
// - Bit 4 picks 6 or 12 periods for serial modes 0 and 2, only with double speed.
// - Bits 3, 2, 1 pick 6 or 12 periods for timers 2, 1, 0, only with double speed.
// - Double-speed bit clear means 12 periods per cycle for core and every peripheral.
// - Double-speed bit set means 6 core periods and enables the peripheral select bits.
// - After power-up the double-speed bit is loaded from the security configuration byte.
// - Without a double-speed request in that byte the bit comes up cleared.
// - The second control register holds the SPI select in bit 0; upper bits reserved.
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

// Printed register offsets are word indices; the bus byte address is four times the index.
`define MCS_CTRL0_IDX 8'h8f
`define MCS_CTRL1_IDX 8'haf
`define MCS_STATUS_IDX 8'hc0
`define MCS_CTRL0_ADDR 12'h23c
`define MCS_CTRL1_ADDR 12'h2bc
`define MCS_STATUS_ADDR 12'h300

// Fields of clock_rate_control_0.
`define MCS_CTRL0_DBL_BIT 0
`define MCS_CTRL0_T0_BIT 1
`define MCS_CTRL0_T1_BIT 2
`define MCS_CTRL0_T2_BIT 3
`define MCS_CTRL0_SER_BIT 4
`define MCS_CTRL0_CNT_BIT 5
`define MCS_CTRL0_MASK 8'h3f
`define MCS_CTRL0_RESET 8'h00

// Fields of clock_rate_control_1.
`define MCS_CTRL1_SPI_BIT 0
`define MCS_CTRL1_MASK 8'h01
`define MCS_CTRL1_RESET 8'h00

// Fields of the status register.
`define MCS_STAT_DBL_EFF_BIT 0
`define MCS_STAT_DBL_PEND_BIT 1
`define MCS_STAT_HALF_BIT 2

// Input clock periods per machine or peripheral cycle.
`define MCS_STD_PERIODS 12
`define MCS_DBL_PERIODS 6
`define MCS_HALF_RATIO 2

`endif

// [rtl/mcs_pkg.sv]
// Types shared by the clock-rate selector modules.
package mcs_pkg;

    // Index of each cycle divider inside the selector.
    typedef enum logic [2:0] {
        MCS_CORE = 3'b000,
        MCS_CNT_ARRAY = 3'b001,
        MCS_SERIAL = 3'b010,
        MCS_TIMER2 = 3'b011,
        MCS_TIMER1 = 3'b100,
        MCS_TIMER0 = 3'b101,
        MCS_SPI = 3'b110
    } mcs_div_idx_e;

    localparam int MCS_NUM_DIV = 7;

    typedef logic [7:0] mcs_byte_t;

endpackage : mcs_pkg

// [rtl/mcs_div_if.sv]
// Link between the selector and one cycle divider.
`timescale 1ns/10ps
`default_nettype none
interface mcs_div_if;
    logic sel_long;
    logic tick;
    modport ctrl (output sel_long, input tick);
    modport div (input sel_long, output tick);
endinterface : mcs_div_if
`default_nettype wire

// [rtl/mcs_div.sv]
// Cycle divider: one-cycle tick every short or long count of input periods.
`timescale 1ns/10ps
`default_nettype none
`include "mcs_regs.svh"
module mcs_div #(
    parameter int SHORT_PERIODS = `MCS_DBL_PERIODS,
    parameter int LONG_PERIODS = `MCS_STD_PERIODS,
    parameter int CNT_W = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Selector link
    mcs_div_if.div lnk
);
    import mcs_pkg::*;

    if (SHORT_PERIODS < 1 || LONG_PERIODS < SHORT_PERIODS ||
            LONG_PERIODS > (1 << CNT_W)) begin : g_bad_param
        $error("mcs_div: period counts do not fit the counter");
    end

    localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(SHORT_PERIODS - 1);
    localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'(LONG_PERIODS - 1);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic tick_q;
    logic tick_d;
    logic [CNT_W-1:0] last;

    // A switch to the short count while past its end wraps at once, so no cycle is lost.
    always_comb begin
        last = lnk.sel_long ? LONG_LAST : SHORT_LAST;
        if (cnt_q >= last) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + CNT_W'(1);
            tick_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign lnk.tick = tick_q;

endmodule : mcs_div
`default_nettype wire

// [testbench/mcs_top_sva.sv]
// Checker for the clock-rate selector: clock outputs, strap load and bus read data.
`timescale 1ns/10ps
`default_nettype none
module mcs_top_sva (
    // Clock, reset and strap
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic SEC_CFG_DBL_I,
    // Bus and outputs
    input wire logic HSEL_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HALF_CLK_O,
    input wire logic CORE_TICK_O,
    input wire logic MACHINE_CYCLE_O,
    input wire logic DOUBLE_SPEED_O
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    logic [4:0] gap_q, gap_d, age_q, age_d;
    logic dbl_q, rd_q, rd_d;
    // Periods close to a mode change are skipped, as the wrap point there is free.
    always_comb begin
        gap_d = MACHINE_CYCLE_O ? 5'h1 : gap_q + {4'h0, gap_q != 5'h1f};
        age_d = (DOUBLE_SPEED_O != dbl_q) ? 5'h0 : age_q + {4'h0, age_q != 5'h1f};
        rd_d = HSEL_I & HREADY_I & HTRANS_I[1] & ~HWRITE_I;
    end
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            {gap_q, age_q, dbl_q, rd_q} <= 12'h0;
        end else begin
            {gap_q, age_q, dbl_q, rd_q} <= {gap_d, age_d, DOUBLE_SPEED_O, rd_d};
        end
    end
    sequence s_release;
        $rose(RST_N_I);
    endsequence
    property p_half;
        $past(RST_N_I) |-> HALF_CLK_O != $past(HALF_CLK_O);
    endproperty
    a_half: assert property (p_half) else $error("half clock stalled");
    property p_cdbl;
        DOUBLE_SPEED_O && $past(DOUBLE_SPEED_O) |-> CORE_TICK_O;
    endproperty
    a_cdbl: assert property (p_cdbl) else $error("core tick missing");
    property p_cstd;
        $past(RST_N_I) && !DOUBLE_SPEED_O && !$past(DOUBLE_SPEED_O) |-> CORE_TICK_O == HALF_CLK_O;
    endproperty
    a_cstd: assert property (p_cstd) else $error("core tick off half clock");
    property p_sync;
        $changed(DOUBLE_SPEED_O) |-> $rose(HALF_CLK_O);
    endproperty
    a_sync: assert property (p_sync) else $error("mode switched off half rise");
    property p_mcyc;
        MACHINE_CYCLE_O && (age_q > gap_q + 5'h3) |-> gap_q == (DOUBLE_SPEED_O ? 5'h6 : 5'hc);
    endproperty
    a_mcyc: assert property (p_mcyc) else $error("machine cycle length");
    property p_rdat;
        HRDATA_O[31:8] == 24'h0 && (rd_q || HRDATA_O == 32'h0);
    endproperty
    a_rdat: assert property (p_rdat) else $error("read data outside phase");
    property p_son;
        s_release ##0 SEC_CFG_DBL_I |-> ##[1:3] DOUBLE_SPEED_O;
    endproperty
    a_son: assert property (p_son) else $error("strap not loaded");
    property p_soff;
        s_release ##0 !SEC_CFG_DBL_I |-> !DOUBLE_SPEED_O [*4];
    endproperty
    a_soff: assert property (p_soff) else $error("double speed without strap");
endmodule : mcs_top_sva
bind mcs_top mcs_top_sva chk_u (.*);
`default_nettype wire

// [testbench/mcs_top_tb.sv]
// Bench for the clock-rate selector: bus access, strap load and cycle rates.
`timescale 1ns/10ps
`default_nettype none
`include "mcs_regs.svh"
module mcs_top_tb
    import mcs_pkg::*;
;
    logic clk, rst_n, sec_dbl, hsel, hwrite, hrdy, hresp, mcyc, dbl;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [5:0] pcyc;
    int mismatches, num_checks;
    mcs_top dut_u (
        .SYS_CLK_I(clk), .RST_N_I(rst_n), .SEC_CFG_DBL_I(sec_dbl), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
        .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy),
        .HRESP_O(hresp), .HALF_CLK_O(), .CORE_TICK_O(), .MACHINE_CYCLE_O(mcyc),
        .PERIPH_CYCLE_O(pcyc), .DOUBLE_SPEED_O(dbl)
    );
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // The slave may stretch either phase, so both waits poll hready.
    task automatic bus(input logic wr, input logic [11:0] a, input mcs_byte_t wd);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0, a};
        do @(posedge clk); while (hrdy !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge clk); while (hrdy !== 1'h1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : bus
    task automatic do_reset(input logic strap);
        rst_n <= 1'h0;
        sec_dbl <= strap;
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        bus(1'h0, `MCS_CTRL0_ADDR, 8'h0);
        chk("ctrl0 after reset", {31'h0, strap}, rd);
        bus(1'h0, `MCS_CTRL1_ADDR, 8'h0);
        chk("ctrl1 after reset", 32'h0, rd);
        chk("double speed after reset", {31'h0, strap}, {31'h0, dbl});
    endtask : do_reset
    task automatic check_unmapped();
        bus(1'h1, 12'h004, 8'hff);
        bus(1'h0, 12'h004, 8'h0);
        chk("unmapped", 32'h0, rd);
    endtask : check_unmapped
    // Windows of 24 periods hold a whole number of 6 and 12 cycles whatever the phase.
    task automatic run_mode(input mcs_byte_t c0, input mcs_byte_t c1);
        logic [5:0] sel;
        logic prev;
        int mc;
        int pc[6];
        sel = {c1[0], c0[1], c0[2], c0[3], c0[4], c0[5]};
        prev = dbl;
        bus(1'h1, `MCS_CTRL0_ADDR, c0);
        // Read straight after the write: the new setting still waits for a halved-clock rise.
        bus(1'h0, `MCS_STATUS_ADDR, 8'h0);
        chk("status pending", {30'h0, c0[0] ^ prev, prev}, rd & 32'hffff_fffb);
        bus(1'h1, `MCS_CTRL1_ADDR, c1);
        bus(1'h0, `MCS_CTRL0_ADDR, 8'h0);
        chk("ctrl0", {24'h0, c0 & 8'h3f}, rd);
        bus(1'h0, `MCS_CTRL1_ADDR, 8'h0);
        chk("ctrl1", {24'h0, c1 & 8'h01}, rd);
        repeat (24) @(posedge clk);
        mc = 0;
        pc = '{default: 0};
        repeat (24) begin
            @(posedge clk);
            mc += (mcyc === 1'h1);
            for (int k = 0; k < 6; k++) pc[k] += (pcyc[k] === 1'h1);
        end
        chk("double speed", {31'h0, c0[0]}, {31'h0, dbl});
        bus(1'h0, `MCS_STATUS_ADDR, 8'h0);
        chk("status settled", {31'h0, c0[0]}, rd & 32'hffff_fffb);
        chk("machine cycles", c0[0] ? 32'h4 : 32'h2, mc);
        for (int k = 0; k < 6; k++) chk("periph cycles", (c0[0] && !sel[k]) ? 4 : 2, pc[k]);
    endtask : run_mode
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwrite <= 1'h0;
        haddr <= 32'h0;
        hwdata <= 32'h0;
        do_reset(1'h0);
        check_unmapped();
        run_mode(8'hff, 8'hff);
        run_mode(8'h15, 8'h01);
        run_mode(8'h2b, 8'h00);
        run_mode(8'h3e, 8'h01);
        do_reset(1'h1);
        tally_and_finish();
    end
endmodule : mcs_top_tb
`default_nettype wire
